//--- common/pcr_pkg.sv
// How it works
// R1 - host shifts data then address, MSB first
// R2 - narrow registers use low bits only
// R3 - enable low; data sampled on clock rise
// R4 - host keeps shift clock high at release
// R5 - frame committed on enable rising edge
// R6 - only last eleven shifted bits are kept
// R7 - divider applied after high, post, low
// R8 - host rewrites all three divider registers
// R9 - data register loads only with enable high
// R10 - readback steps 41 items, then wraps
// R11 - scan chain reloads whenever registers change
// R12 - readback works only with readback power
// R13 - chip power low turns device off
// R14 - core power off keeps registers only
// R15 - counter pin driven only when enabled
// R16 - force load copies registers into counter
// R17 - counter source: oscillator or test clock
// R18 - six ttl enables plus two polarities
// R19 - delay, pump and detector fields layout
// R20 - hold: sync low gives low, else keep
// R21 - hold: counter pulse low forces high
// R22 - new divide loads when counter hits zero
// R23 - ratio is (upper+1)*8 plus lower bits
// R24 - coarse code adds one to four clocks
// R25 - pump code selects 100/400/1600 microamps
// R26 - bad address or chip off ignores frame
package pcr_pkg;

    // ----------
    // serial frame
    // ----------
    localparam int       ADDR_W     = 3;
    localparam int       DATA_W     = 8;
    localparam logic [3:0] FRAME_BITS = 4'hb;

    localparam logic [2:0] ADDR_DIV_LOW  = 3'h1;
    localparam logic [2:0] ADDR_DIV_HIGH = 3'h2;
    localparam logic [2:0] ADDR_POST_DIV = 3'h3;
    localparam logic [2:0] ADDR_DELAY    = 3'h4;
    localparam logic [2:0] ADDR_PUMP     = 3'h5;
    localparam logic [2:0] ADDR_POLARITY = 3'h6;
    localparam logic [2:0] ADDR_TEST     = 3'h7;

    // ----------
    // field positions
    // ----------
    localparam int FINE_LSB       = 0;
    localparam int COARSE_LSB     = 5;
    localparam int PUMP_LSB       = 0;
    localparam int PHASE_DET_POLARITY_BIT     = 2;
    localparam int SYNC_IN_POLARITY_BIT   = 0;
    localparam int DELAYED_SYNC_OUT_POLARITY_BIT  = 1;
    localparam int TTL_EN_LSB     = 2;
    localparam int DELAYED_SYNC_TTL_BIT  = 6;
    localparam int OSC_SEL_BIT    = 0;
    localparam int CORE_PWR_BIT   = 1;
    localparam int READ_PWR_BIT   = 2;
    localparam int CNT_OUT_BIT    = 3;
    localparam int DIV_N_BITS     = 3;
    localparam int DIV_CNT_W      = 13;

    // ----------
    // reset values
    // ----------
    localparam logic [7:0] RST_DIV_LOW  = 8'h00;
    localparam logic [3:0] RST_DIV_HIGH = 4'h4;
    localparam logic [1:0] RST_POST     = 2'h0;
    localparam logic [6:0] RST_DELAY    = 7'h00;
    localparam logic [2:0] RST_PUMP     = 3'h4;
    localparam logic [7:0] RST_POLARITY = 8'hff;
    localparam logic [3:0] RST_TEST     = 4'h3;
    localparam logic [12:0] DIV_ROUND   = 13'h0007;

    // ----------
    // pins and scan chain
    // ----------
    localparam int PIN_SCLK    = 0;
    localparam int PIN_SEN_N   = 1;
    localparam int PIN_SERIAL_DATA_IN   = 2;
    localparam int PIN_CS      = 3;
    localparam int PIN_FORCE_COUNTER_LOAD_N_N = 4;
    localparam int PIN_HOLD    = 5;
    localparam int PIN_SYNC    = 6;
    localparam int PIN_OSC     = 7;
    localparam int PIN_TCLK    = 8;
    localparam int PIN_COUNT   = 9;
    localparam logic [8:0] PIN_IDLE = 9'h013;

    localparam int         CHAIN_LEN  = 41;
    localparam int         CHAIN_IDX_W = 6;
    localparam logic [5:0] CHAIN_LAST = 6'h28;
    localparam logic [4:0] CHAIN_FILL = 5'h00;

    typedef logic [CHAIN_LEN-1:0] pcr_chain_type;

endpackage

//--- common/pcr_scan_if.sv
`timescale 1ns/10ps
interface pcr_scan_if;
    import pcr_pkg::*;
    pcr_chain_type chain;    // live register contents, first item at msb
    logic          step;     // one shift clock pulse taken in read mode
    logic          enable;   // readback powered
    logic          bit_out;  // registered readback bit

    modport ctrl (output chain, output step, output enable, input bit_out);
    modport scan (input chain, input step, input enable, output bit_out);
endinterface

//--- hdl/pcr_scan_chain.sv
`timescale 1ns/10ps
module pcr_scan_chain
    import pcr_pkg::*;
(
    input  wire logic clock_in,   // system clock
    input  wire logic arst_n_in,  // async reset, active low
    pcr_scan_if.scan  scan_bus    // chain contents and step control
);

    pcr_chain_type          snap_reg;
    pcr_chain_type          snap_next;
    logic [CHAIN_IDX_W-1:0] idx_reg;
    logic [CHAIN_IDX_W-1:0] idx_next;
    logic                   bit_reg;
    logic                   bit_next;
    logic                   changed;

    // ----------
    // scan path
    // ----------
    always_comb begin
        changed   = (scan_bus.chain != snap_reg);
        snap_next = changed ? scan_bus.chain : snap_reg;  // R11
        idx_next  = idx_reg;
        bit_next  = bit_reg;
        if (!scan_bus.enable) begin
            idx_next = '0;  // R12
            bit_next = 1'b0;  // R12
        end else if (scan_bus.step) begin
            // same-cycle change is shown at once
            bit_next = snap_next[CHAIN_LAST - idx_reg];  // R10
            idx_next = (idx_reg == CHAIN_LAST) ? '0 : idx_reg + 6'h01;  // R10
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            snap_reg <= '0;
            idx_reg  <= '0;
            bit_reg  <= 1'b0;
        end else begin
            snap_reg <= snap_next;
            idx_reg  <= idx_next;
            bit_reg  <= bit_next;
        end
    end

    assign scan_bus.bit_out = bit_reg;

endmodule

//--- hdl/pcr_ctrl_regs.sv
`timescale 1ns/10ps
module pcr_ctrl_regs
    import pcr_pkg::*;
(
    input  wire logic        clock_in,                  // system clock, 50 MHz
    input  wire logic        arst_n_in,                 // async reset, active low
    input  wire logic        shift_clk_in,              // serial shift clock pin
    input  wire logic        serial_frame_enable_n_in,  // serial enable pin, active low
    input  wire logic        serial_data_in,            // serial data pin
    input  wire logic        chip_power_in,             // chip power select, high = on
    input  wire logic        force_counter_load_n_in,   // force counter load, active low
    input  wire logic        phase_hold_in,             // phase detector hold
    input  wire logic        sync_in,                   // sync input level
    input  wire logic        osc_clk_in,                // internal oscillator level
    input  wire logic        test_clk_in,               // external test clock level
    output logic             readback_out,              // serial readback bit
    output logic             counter_out,               // feedback counter pulse
    output logic             delayed_sync_out,          // delayed sync level
    output logic [11:0]      feedback_divide_out,       // applied feedback divide
    output logic [1:0]       post_divider_sel_out,      // applied post divider code
    output logic [4:0]       fine_delay_out,            // fine delay code
    output logic [1:0]       coarse_delay_out,          // coarse delay code
    output logic [1:0]       pump_current_sel_out,      // charge pump current code
    output logic             phase_det_polarity_out,    // phase detector polarity
    output logic [5:0]       ttl_enables_out,           // clk, nclk, clk2, nclk2, delayed_sync, lock-loss
    output logic             core_power_on_out,         // core powered
    output logic             device_on_out              // chip power select seen high
);

    // ----------
    // pin synchronisers
    // ----------
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] meta_reg;
    logic [PIN_COUNT-1:0] mid_reg;
    logic [PIN_COUNT-1:0] last_reg;
    logic [PIN_COUNT-1:0] pin_reg;
    logic [PIN_COUNT-1:0] pin_next;
    logic [PIN_COUNT-1:0] prev_reg;

    assign pin_raw = {test_clk_in, osc_clk_in, sync_in, phase_hold_in, force_counter_load_n_in,
                      chip_power_in, serial_data_in, serial_frame_enable_n_in, shift_clk_in};

    // a level is taken only once the second and third stages agree
    always_comb begin
        pin_next = (mid_reg & last_reg) | (pin_reg & (mid_reg ^ last_reg));
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_reg <= PIN_IDLE;
            mid_reg  <= PIN_IDLE;
            last_reg <= PIN_IDLE;
            pin_reg  <= PIN_IDLE;
            prev_reg <= PIN_IDLE;
        end else begin
            meta_reg <= pin_raw;
            mid_reg  <= meta_reg;
            last_reg <= mid_reg;
            pin_reg  <= pin_next;
            prev_reg <= pin_reg;
        end
    end

    logic sclk_rise;
    logic frame_end;
    logic enabled;
    logic chip_on;

    always_comb begin
        enabled   = ~pin_reg[PIN_SEN_N];  // R3
        sclk_rise = pin_reg[PIN_SCLK] & ~prev_reg[PIN_SCLK];  // R3
        frame_end = pin_reg[PIN_SEN_N] & ~prev_reg[PIN_SEN_N];  // R5
        chip_on   = pin_reg[PIN_CS];  // R13
    end

    // ----------
    // serial shift register
    // ----------
    logic [10:0] shift_reg;
    logic [10:0] shift_next;
    logic [3:0]  bits_reg;
    logic [3:0]  bits_next;

    always_comb begin
        shift_next = shift_reg;
        bits_next  = bits_reg;
        if (enabled && sclk_rise) begin
            // only the last eleven bits survive
            shift_next = {shift_reg[9:0], pin_reg[PIN_SERIAL_DATA_IN]};  // R6
            if (bits_reg != FRAME_BITS) begin
                bits_next = bits_reg + 4'h1;
            end
        end
        if (frame_end) begin
            bits_next = 4'h0;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_reg <= '0;
            bits_reg  <= 4'h0;
        end else begin
            shift_reg <= shift_next;
            bits_reg  <= bits_next;
        end
    end

    // ----------
    // control registers
    // ----------
    logic [7:0]  div_low_reg;
    logic [7:0]  div_low_next;
    logic [3:0]  div_high_reg;
    logic [3:0]  div_high_next;
    logic [1:0]  post_div_reg;
    logic [1:0]  post_div_next;
    logic [6:0]  delay_reg;
    logic [6:0]  delay_next;
    logic [2:0]  pump_reg;
    logic [2:0]  pump_next;
    logic [7:0]  polarity_reg;
    logic [7:0]  polarity_next;
    logic [3:0]  test_reg;
    logic [3:0]  test_next;
    logic [11:0] active_div_reg;
    logic [11:0] active_div_next;
    logic [1:0]  active_post_reg;
    logic [1:0]  active_post_next;
    logic        seen_high_reg;
    logic        seen_high_next;
    logic        seen_post_reg;
    logic        seen_post_next;
    logic [2:0]  frame_addr;
    logic [7:0]  frame_data;
    logic        accept;

    always_comb begin
        frame_addr       = shift_reg[ADDR_W-1:0];  // R1
        frame_data       = shift_reg[ADDR_W+DATA_W-1:ADDR_W];  // R1
        // short frames and frames while the chip is off change nothing
        accept           = frame_end && (bits_reg == FRAME_BITS) && chip_on;  // R9 R26
        div_low_next     = div_low_reg;
        div_high_next    = div_high_reg;
        post_div_next    = post_div_reg;
        delay_next       = delay_reg;
        pump_next        = pump_reg;
        polarity_next    = polarity_reg;
        test_next        = test_reg;
        active_div_next  = active_div_reg;
        active_post_next = active_post_reg;
        seen_high_next   = seen_high_reg;
        seen_post_next   = seen_post_reg;
        if (accept) begin
            case (frame_addr)
                ADDR_DIV_LOW: begin
                    div_low_next = frame_data;
                    if (seen_high_reg && seen_post_reg) begin
                        active_div_next  = {div_high_reg, frame_data};  // R7
                        active_post_next = post_div_reg;  // R7
                        seen_high_next   = 1'b0;
                        seen_post_next   = 1'b0;
                    end
                end
                ADDR_DIV_HIGH: begin
                    div_high_next  = frame_data[3:0];  // R2
                    seen_high_next = 1'b1;  // R7
                    seen_post_next = 1'b0;
                end
                ADDR_POST_DIV: begin
                    post_div_next  = frame_data[1:0];  // R2
                    seen_post_next = seen_high_reg;  // R7
                end
                ADDR_DELAY:    delay_next    = frame_data[6:0];  // R2 R19
                ADDR_PUMP:     pump_next     = frame_data[2:0];  // R19
                ADDR_POLARITY: polarity_next = frame_data;  // R18
                ADDR_TEST:     test_next     = frame_data[3:0];  // R2
                default: ;  // R26
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_low_reg     <= RST_DIV_LOW;
            div_high_reg    <= RST_DIV_HIGH;
            post_div_reg    <= RST_POST;
            delay_reg       <= RST_DELAY;
            pump_reg        <= RST_PUMP;
            polarity_reg    <= RST_POLARITY;
            test_reg        <= RST_TEST;
            active_div_reg  <= {RST_DIV_HIGH, RST_DIV_LOW};
            active_post_reg <= RST_POST;
            seen_high_reg   <= 1'b0;
            seen_post_reg   <= 1'b0;
        end else begin
            div_low_reg     <= div_low_next;
            div_high_reg    <= div_high_next;
            post_div_reg    <= post_div_next;
            delay_reg       <= delay_next;
            pump_reg        <= pump_next;
            polarity_reg    <= polarity_next;
            test_reg        <= test_next;
            active_div_reg  <= active_div_next;
            active_post_reg <= active_post_next;
            seen_high_reg   <= seen_high_next;
            seen_post_reg   <= seen_post_next;
        end
    end

    // ----------
    // feedback counter
    // ----------
    logic [DIV_CNT_W-1:0] cnt_reg;
    logic [DIV_CNT_W-1:0] cnt_next;
    logic [DIV_CNT_W-1:0] ratio_m1;
    logic [DIV_CNT_W-1:0] force_m1;
    logic                 pulse_reg;
    logic                 pulse_next;
    logic                 src_prev_reg;
    logic                 src_next;
    logic                 src_rise;
    logic                 running;
    logic                 power_on_reg;
    logic                 power_on_next;
    logic                 counter_out_reg;
    logic                 counter_out_next;

    // terminal count is ratio minus one, i.e. upper*8 + 7 + lower
    always_comb begin
        ratio_m1 = {1'b0, active_div_reg[11:DIV_N_BITS], 3'h0} + DIV_ROUND
                   + {10'h000, active_div_reg[DIV_N_BITS-1:0]};  // R23
        force_m1 = {1'b0, div_high_reg, div_low_reg[7:DIV_N_BITS], 3'h0} + DIV_ROUND
                   + {10'h000, div_low_reg[DIV_N_BITS-1:0]};  // R16 R23
        running  = power_on_reg;  // R13 R14
        src_next = test_reg[OSC_SEL_BIT] ? pin_reg[PIN_OSC] : pin_reg[PIN_TCLK];  // R17
        src_rise = src_next & ~src_prev_reg;
        cnt_next = cnt_reg;
        if (!running) begin
            cnt_next = cnt_reg;  // R14
        end else if (!pin_reg[PIN_FORCE_COUNTER_LOAD_N_N]) begin
            cnt_next = force_m1;  // R16
        end else if (src_rise) begin
            if (cnt_reg == '0) begin
                cnt_next = ratio_m1;  // R22
            end else begin
                cnt_next = cnt_reg - 13'h0001;
            end
        end
        pulse_next       = running && (cnt_next == '0);
        counter_out_next = pulse_next & test_reg[CNT_OUT_BIT];  // R15
        power_on_next    = chip_on & test_reg[CORE_PWR_BIT];  // R13 R14
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_reg         <= '0;
            pulse_reg       <= 1'b0;
            src_prev_reg    <= 1'b0;
            power_on_reg    <= 1'b0;
            counter_out_reg <= 1'b0;
        end else begin
            cnt_reg         <= cnt_next;
            pulse_reg       <= pulse_next;
            src_prev_reg    <= src_next;
            power_on_reg    <= power_on_next;
            counter_out_reg <= counter_out_next;
        end
    end

    // ----------
    // delayed sync
    // ----------
    logic [3:0] sync_line_reg;
    logic [3:0] sync_line_next;
    logic       delayed_sync_int_reg;
    logic       delayed_sync_int_next;
    logic       delayed_sync_out_reg;
    logic       delayed_sync_out_next;
    logic       sync_int;
    logic       counter_pulse_n;

    always_comb begin
        sync_int        = pin_reg[PIN_SYNC] ~^ polarity_reg[SYNC_IN_POLARITY_BIT];  // R18
        counter_pulse_n = ~pulse_reg;
        sync_line_next  = {sync_line_reg[2:0], sync_int};
        // code 0 taps the first stage, one clock late
        delayed_sync_int_next  = sync_line_reg[delay_reg[COARSE_LSB+1:COARSE_LSB]];  // R24
        if (pin_reg[PIN_HOLD]) begin
            if (counter_pulse_n) begin
                delayed_sync_int_next = 1'b1;  // R21
            end else if (!sync_int) begin
                delayed_sync_int_next = 1'b0;  // R20
            end else begin
                delayed_sync_int_next = delayed_sync_int_reg;  // R20
            end
        end
        delayed_sync_out_next = (delayed_sync_int_next ~^ polarity_reg[DELAYED_SYNC_OUT_POLARITY_BIT])
                         & polarity_reg[DELAYED_SYNC_TTL_BIT] & running;  // R18 R14
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_line_reg <= 4'h0;
            delayed_sync_int_reg <= 1'b0;
            delayed_sync_out_reg <= 1'b0;
        end else begin
            sync_line_reg <= sync_line_next;
            delayed_sync_int_reg <= delayed_sync_int_next;
            delayed_sync_out_reg <= delayed_sync_out_next;
        end
    end

    // ----------
    // readback
    // ----------
    pcr_scan_if scan_bus ();

    assign scan_bus.chain  = {div_low_reg, div_high_reg, post_div_reg, delay_reg, pump_reg,
                              polarity_reg, test_reg[3:1], CHAIN_FILL, test_reg[OSC_SEL_BIT]};  // R10 R11
    assign scan_bus.step   = sclk_rise & ~enabled & chip_on;  // R10
    assign scan_bus.enable = test_reg[READ_PWR_BIT] & chip_on;  // R12

    pcr_scan_chain u_scan (
        .clock_in  (clock_in),
        .arst_n_in (arst_n_in),
        .scan_bus  (scan_bus)
    );

    // ----------
    // outputs
    // ----------
    // pump code 01 passes through unchecked
    assign readback_out           = scan_bus.bit_out;
    assign counter_out            = counter_out_reg;
    assign delayed_sync_out       = delayed_sync_out_reg;
    assign feedback_divide_out    = active_div_reg;
    assign post_divider_sel_out   = active_post_reg;
    assign fine_delay_out         = delay_reg[COARSE_LSB-1:FINE_LSB];
    assign coarse_delay_out       = delay_reg[COARSE_LSB+1:COARSE_LSB];
    assign pump_current_sel_out   = pump_reg[PUMP_LSB+1:PUMP_LSB];  // R25
    assign phase_det_polarity_out = pump_reg[PHASE_DET_POLARITY_BIT];
    assign ttl_enables_out        = polarity_reg[7:TTL_EN_LSB];
    assign core_power_on_out      = power_on_reg;
    assign device_on_out          = chip_on;

endmodule

//--- bench/pcr_monitor.sv
`timescale 1ns/10ps
// ----------
// register bank checker
// ----------
module pcr_monitor (
    input wire logic        clock_in,                 // clock
    input wire logic        arst_n_in,                // reset
    input wire logic        shift_clk_in,             // shift clock
    input wire logic        serial_frame_enable_n_in, // frame enable
    input wire logic        chip_power_in,            // chip power
    input wire logic        readback_out,             // readback bit
    input wire logic        delayed_sync_out,         // delayed sync
    input wire logic [11:0] feedback_divide_out,      // divide
    input wire logic [1:0]  post_divider_sel_out,     // post divider
    input wire logic [4:0]  fine_delay_out,           // fine delay
    input wire logic [1:0]  coarse_delay_out,         // coarse delay
    input wire logic [1:0]  pump_current_sel_out,     // pump code
    input wire logic        phase_det_polarity_out,   // pd polarity
    input wire logic [5:0]  ttl_enables_out,          // ttl enables
    input wire logic        core_power_on_out,        // core on
    input wire logic        device_on_out             // device on
);
    logic [29:0] fields;
    logic [3:0]  idle_reg, idle_next;
    logic [2:0]  pins_reg, pins_next;

    assign fields = {feedback_divide_out, post_divider_sel_out, fine_delay_out, coarse_delay_out,
                     pump_current_sel_out, phase_det_polarity_out, ttl_enables_out};

    // cycles since a pin moved, saturating
    always_comb begin
        pins_next = {shift_clk_in, serial_frame_enable_n_in, chip_power_in};
        idle_next = (pins_next != pins_reg) ? 4'h0 : idle_reg + {3'h0, idle_reg != 4'hf};
    end
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pins_reg <= 3'h0;
            idle_reg <= 4'h0;
        end else begin
            pins_reg <= pins_next;
            idle_reg <= idle_next;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_power_low;
        !chip_power_in [*8];
    endsequence
    sequence s_power_high;
        chip_power_in [*8];
    endsequence
    sequence s_frame_open;
        !serial_frame_enable_n_in [*8];
    endsequence

    chip_on_a: assert property (s_power_high |-> device_on_out)
        else $error("device off");
    chip_off_a: assert property (s_power_low |-> !device_on_out)
        else $error("device on");
    core_gated_a: assert property (!device_on_out [*2] |-> !core_power_on_out)
        else $error("core on");
    delayed_sync_off_a: assert property (!device_on_out [*3] |-> !delayed_sync_out)
        else $error("delayed_sync on");
    fields_commit_a: assert property ($changed(fields) |-> $past(serial_frame_enable_n_in, 3))
        else $error("early commit");
    shift_quiet_a: assert property (s_frame_open |-> $stable(fields))
        else $error("commit in frame");
    fields_frozen_a: assert property (idle_reg == 4'hf |-> $stable(fields))
        else $error("field moved idle");
    readback_still_a: assert property (idle_reg == 4'hf |-> $stable(readback_out))
        else $error("readback moved");
endmodule

bind pcr_ctrl_regs pcr_monitor i_mon (.clock_in, .arst_n_in, .shift_clk_in, .serial_frame_enable_n_in,
    .chip_power_in, .readback_out, .delayed_sync_out, .feedback_divide_out, .post_divider_sel_out,
    .fine_delay_out, .coarse_delay_out, .pump_current_sel_out, .phase_det_polarity_out,
    .ttl_enables_out, .core_power_on_out, .device_on_out);

//--- bench/pcr_host_model.sv
`timescale 1ns/10ps
// ----------
// host side of the three-wire link
// ----------
module pcr_host_model (
    input  wire logic clock_in,     // system clock
    input  wire logic readback_out, // device readback bit
    output logic      sclk_out = 1'b1,  // shift clock, idles high
    output logic      sen_n_out = 1'b1, // frame enable, active low
    output logic      serial_data_in_out = 1'b0  // serial data
);
    int half = 4; // cycles per clock phase

    // a released data line must not look like the last bit sent
    always @(posedge clock_in) begin
        if (sen_n_out) begin
            serial_data_in_out <= ~serial_data_in_out;
        end
    end

    task automatic pause(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    task automatic send(input logic [15:0] bits, input int n);
        sen_n_out <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            pause(half);
            sclk_out <= 1'b0;
            serial_data_in_out <= bits[i];
        pause(half);
            sclk_out <= 1'b1;
        end
        pause(half);
        sen_n_out <= 1'b1;
        pause(4 * half);
    endtask

    task automatic pulse(output logic b);
        sclk_out <= 1'b0;
        pause(half);
        sclk_out <= 1'b1;
        pause(2 * half);
        b = readback_out;
    endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import pcr_pkg::*;
    logic        clock_in = 1'b0, arst_n_in = 1'b0, chip_power_in = 1'b1, phase_hold_in = 1'b0, sync_in = 1'b0;
    logic        shift_clk_in, serial_frame_enable_n_in, serial_data_in, readback_out, delayed_sync_out;
    logic        phase_det_polarity_out, core_power_on_out, device_on_out, b;
    logic [11:0] feedback_divide_out;
    logic [5:0]  ttl_enables_out;
    logic [4:0]  fine_delay_out;
    logic [1:0]  post_divider_sel_out, coarse_delay_out, pump_current_sel_out;
    logic [40:0] chain;
    int          fail_count = 0, n_compared = 0, cycles = 0;

    always #10 clock_in = ~clock_in;

    pcr_ctrl_regs i_dut (
        .clock_in, .arst_n_in, .shift_clk_in, .serial_frame_enable_n_in, .serial_data_in, .chip_power_in,
        .force_counter_load_n_in(1'b1), .phase_hold_in, .sync_in, .osc_clk_in(1'b0),
        .test_clk_in(1'b0), .readback_out, .counter_out(), .delayed_sync_out, .feedback_divide_out,
        .post_divider_sel_out, .fine_delay_out, .coarse_delay_out, .pump_current_sel_out,
        .phase_det_polarity_out, .ttl_enables_out, .core_power_on_out, .device_on_out
    );
    pcr_host_model i_host (.clock_in, .readback_out, .sclk_out(shift_clk_in),
        .sen_n_out(serial_frame_enable_n_in), .serial_data_in_out(serial_data_in));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_host.send({5'h00, d, a}, 11);
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        repeat (2) @(posedge clock_in);
        arst_n_in <= 1'b1;
        i_host.pause(10);
        chk("divide", feedback_divide_out, 12'h400);
        chk("ttl", ttl_enables_out, 6'h3f);
        chk("device on", device_on_out, 1'b1);
        wr(ADDR_DELAY, 8'hf3);
        chk("fine", fine_delay_out, 5'h13);
        chk("coarse", coarse_delay_out, 2'h3);
        i_host.half = 6;
        i_host.send({5'h1f, 8'h06, ADDR_PUMP}, 16);
        i_host.half = 4;
        chk("pump", pump_current_sel_out, 2'h2);
        chk("phase_det_polarity", phase_det_polarity_out, 1'b1);
        wr(ADDR_POLARITY, 8'he4);
        chk("ttl", ttl_enables_out, 6'h39);
        wr(ADDR_DIV_HIGH, 8'hf3);
        wr(ADDR_POST_DIV, 8'h02);
        chk("divide", feedback_divide_out, 12'h400);
        chk("post", post_divider_sel_out, 2'h0);
        wr(ADDR_DIV_LOW, 8'ha1);
        chk("divide", feedback_divide_out, 12'h3a1);
        chk("post", post_divider_sel_out, 2'h2);
        wr(3'h0, 8'h55);
        chk("divide", feedback_divide_out, 12'h3a1);
        chip_power_in <= 1'b0;
        i_host.pause(10);
        chk("device on", device_on_out, 1'b0);
        chk("core on", core_power_on_out, 1'b0);
        wr(ADDR_DELAY, 8'h00);
        chip_power_in <= 1'b1;
        i_host.pause(10);
        chk("fine", fine_delay_out, 5'h13);
        chk("core on", core_power_on_out, 1'b1);
        {phase_hold_in, sync_in} <= 2'h3;
        i_host.pause(10);
        chk("delayed_sync", delayed_sync_out, 1'b1);
        wr(ADDR_TEST, 8'h05);
        chk("core on", core_power_on_out, 1'b0);
        chain = {8'ha1, 4'h3, 2'h2, 7'h73, 3'h6, 8'he4, 3'h2, 5'h00, 1'h1};
        for (int i = 0; i < 42; i++) begin
            i_host.pulse(b);
            chk("readback", b, chain[40 - (i % 41)]);
        end
        wr(ADDR_TEST, 8'h03);
        i_host.pulse(b);
        chk("readback off", b, 1'b0);
        chk("core on", core_power_on_out, 1'b1);
        test_done();
    end
endmodule
